/* File: bench/oag_rom_model.sv */
`timescale 1ns/1ps
module oag_rom_model (
	input wire logic i_core_clk,
	input wire logic i_rom_rd,
	input wire logic [oag_pkg::OAG_PCW-1:0] i_rom_addr,
	output logic [oag_pkg::OAG_DW-1:0] o_rom_data
);
	import oag_pkg::*;
	logic [OAG_DW-1:0] last = 8'h00;
	////////////////////////////////////////////////////////////////
	// Byte mixes both address halves, so a wrong upper field shows
	always_comb
	begin
		if (i_rom_rd)
			o_rom_data = i_rom_addr[7:0] ^ {1'b0, i_rom_addr[14:8]};
		else
			o_rom_data = ~last;
	end
	// Idle bus never repeats the last byte
	always_ff @(posedge i_core_clk)
	begin
		if (i_rom_rd)
			last <= o_rom_data;
	end
endmodule : oag_rom_model

/* File: bench/operand_address_generation_tb.sv */
`timescale 1ns/1ps
module operand_address_generation_tb;
	import oag_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic valid = 1'b0;
	logic done = 1'b0;
	oag_req_s rq = '0;
	oag_wr_s wr = '0;
	logic [7:0] acc = 8'h00;
	logic [6:0] pcu = 7'h00;
	logic [7:0] rom_data;
	logic busy, ov, dmrd, noop, romrd;
	logic [7:0] op, p1, p2, sp, bk;
	logic [8:0] dma;
	logic [14:0] roma;
	int errors = 0;
	int n_compared = 0;
	always #12.5 clk = ~clk;
	////////////////////////////////////////////////////////////////
	oag_core i_dut (.i_core_clk(clk), .i_rst(rst), .i_req_valid(valid), .i_req(rq),
		.i_exec_done(done), .i_acc(acc), .i_pc_upper(pcu), .i_wr(wr), .i_rom_data(rom_data),
		.o_busy(busy), .o_operand_valid(ov), .o_operand(op), .o_dm_rd(dmrd), .o_dm_addr(dma),
		.o_no_operand(noop), .o_rom_rd(romrd), .o_rom_addr(roma), .o_ptr_one(p1),
		.o_ptr_two(p2), .o_stack_ptr(sp), .o_upper_bank(bk));
	oag_rom_model i_rom (.i_core_clk(clk), .i_rom_rd(romrd), .i_rom_addr(roma), .o_rom_data(rom_data));
	////////////////////////////////////////////////////////////////
	task automatic cmp_v(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("Error at %0t: got %0h exp %0h", $time, g, e);
		end
	endtask : cmp_v
	task automatic cmp_f(input logic g, input logic e);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("Error at %0t: got %0h exp %0h", $time, g, e);
		end
	endtask : cmp_f
	task automatic wr_mem(input logic [8:0] a, input logic [7:0] d);
		@(negedge clk);
		wr = '{1'b1, a, d};
		@(negedge clk);
		wr.en = 1'b0;
	endtask : wr_mem
	// Returns half a cycle after the taking edge, when the answer pulses stand
	task automatic req(input oag_mode_e m, input logic two, input logic dec, input logic [7:0] f);
		@(negedge clk);
		valid = 1'b1;
		rq = '{m, two, dec, f};
		@(negedge clk);
		valid = 1'b0;
	endtask : req
	task automatic finish_instr;
		@(negedge clk);
		done = 1'b1;
		@(negedge clk);
		done = 1'b0;
	endtask : finish_instr
	task automatic tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		cmp_v({p1, p2}, 16'h0000);
		cmp_v({sp, bk}, 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 16; i++)
			wr_mem(9'h0F0 + 9'(i), 8'h30 + 8'(i));
		cmp_v({p2, sp}, 16'h3C3D);
		cmp_v({p1, bk}, 16'h3E3F);
		for (int i = 0; i < 16; i++)
		begin
			req(OAG_M_DIRECT, 1'b0, 1'b0, 8'hF0 + 8'(i));
			cmp_f(dmrd & ov, 1'b1);
			cmp_v(16'(dma), 16'h00F0 + 16'(i));
			cmp_v(16'(op), 16'h0030 + 16'(i));
		end
		$display("test register window done");
		// Bank bit is set by the 3F written above; 140 is past the top
		for (int i = 0; i < 64; i++)
			wr_mem(9'h100 + 9'(i), 8'hC0 ^ 8'(i));
		for (int i = 0; i < 65; i++)
		begin
			req(OAG_M_DIRECT, 1'b0, 1'b0, 8'(i));
			cmp_v(16'(dma), 16'h0100 + 16'(i));
			cmp_v(16'(op), (i < 64) ? 16'(8'hC0 ^ 8'(i)) : 16'(OAG_UNMAPPED_DATA));
		end
		$display("test upper ram done");
		wr_mem(OAG_PTR_ONE_ADDR, 8'h05);
		wr_mem(OAG_PTR_TWO_ADDR, 8'hF2);
		req(OAG_M_INDIRECT, 1'b0, 1'b0, 8'h00);
		cmp_v({7'h00, dma}, 16'h0105);
		cmp_v(16'(op), 16'h00C5);
		req(OAG_M_INDIRECT, 1'b1, 1'b0, 8'h00);
		cmp_v({7'h00, dma}, 16'h00F2);
		cmp_v(16'(op), 16'h0032);
		$display("test indirect done");
		wr_mem(OAG_PTR_ONE_ADDR, 8'h00);
		req(OAG_M_INDIRECT_ADJ, 1'b0, 1'b1, 8'h00);
		cmp_v(16'(op), 16'h00C0);
		repeat (3) @(negedge clk);
		cmp_v(16'(p1), 16'h0000);
		finish_instr();
		cmp_v(16'(p1), 16'h00FF);
		wr_mem(OAG_PTR_TWO_ADDR, 8'hFF);
		req(OAG_M_INDIRECT_ADJ, 1'b1, 1'b0, 8'h00);
		cmp_v(16'(op), 16'h003F);
		finish_instr();
		cmp_v(16'(p2), 16'h0000);
		// Pointer one still holds FF here, so the increment must wrap to 00
		req(OAG_M_INDIRECT_ADJ, 1'b0, 1'b0, 8'h00);
		cmp_v(16'(op), 16'h003F);
		cmp_v(16'(p1), 16'h00FF);
		finish_instr();
		cmp_v(16'(p1), 16'h0000);
		$display("test adjust done");
		req(OAG_M_IMMEDIATE, 1'b0, 1'b0, 8'hA5);
		cmp_f(dmrd, 1'b0);
		cmp_v(16'(op), 16'h00A5);
		req(OAG_M_SHORT_IMM, 1'b0, 1'b0, 8'h7C);
		cmp_f(ov, 1'b1);
		cmp_v(16'(op), 16'({OAG_SI_PAD, 4'hC}));
		$display("test immediate done");
		acc = 8'h3C;
		pcu = 7'h55;
		req(OAG_M_ROM_TABLE, 1'b0, 1'b0, 8'h00);
		cmp_f(romrd & busy, 1'b1);
		cmp_v(16'(roma), 16'h553C);
		@(negedge clk);
		cmp_f(ov, 1'b1);
		cmp_v(16'(op), 16'h0069);
		$display("test table load done");
		for (int i = 6; i < 10; i++)
		begin
			req(oag_mode_e'(i), 1'b0, 1'b0, 8'h00);
			cmp_f(noop & ~ov, 1'b1);
		end
		$display("test control modes done");
		tally_and_finish();
	end
	// Tests need under 1000 cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		errors++;
		tally_and_finish();
	end
endmodule : operand_address_generation_tb

/* File: hw/oag_core.sv */
`timescale 1ns/1ps
// What this block does
// - Ten modes: six operand, four control
// - Indirect operand addressed by either pointer
// - Pointer adjusts only after instruction completes
// - Direct mode uses 8-bit address field
// - Immediate mode: 8-bit field, no memory access
// - F0 to FB are register RAM
// - 100 to 13F are 64 more bytes
// - Short immediate gives 4-bit field operand
// - Table load reads program memory at upper,accumulator
// - Register operands address F0 to FF
module oag_core (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_req_valid,
	input oag_pkg::oag_req_s i_req,
	input wire logic i_exec_done,
	input wire logic [oag_pkg::OAG_DW-1:0] i_acc,
	input wire logic [oag_pkg::OAG_PUW-1:0] i_pc_upper,
	input oag_pkg::oag_wr_s i_wr,
	input wire logic [oag_pkg::OAG_DW-1:0] i_rom_data,
	output logic o_busy,
	output logic o_operand_valid,
	output logic [oag_pkg::OAG_DW-1:0] o_operand,
	output logic o_dm_rd,
	output logic [oag_pkg::OAG_AW-1:0] o_dm_addr,
	output logic o_no_operand,
	output logic o_rom_rd,
	output logic [oag_pkg::OAG_PCW-1:0] o_rom_addr,
	output logic [oag_pkg::OAG_DW-1:0] o_ptr_one,
	output logic [oag_pkg::OAG_DW-1:0] o_ptr_two,
	output logic [oag_pkg::OAG_DW-1:0] o_stack_ptr,
	output logic [oag_pkg::OAG_DW-1:0] o_upper_bank
);
	import oag_pkg::*;

	typedef enum logic [0:0] {OAG_S_IDLE, OAG_S_ROM} oag_state_e;

	////////////////////////////////////////////////////////////////////////
	// Storage
	logic [OAG_DW-1:0] regram [OAG_REGRAM_DEPTH];
	logic [OAG_DW-1:0] hiram [OAG_HIRAM_DEPTH];
	logic [OAG_DW-1:0] ptr_one_r, ptr_one_nxt, ptr_two_r, ptr_two_nxt;
	logic [OAG_DW-1:0] stack_r, stack_nxt, bank_r, bank_nxt;
	logic pend_r, pend_nxt, pend_two_r, pend_two_nxt, pend_dec_r, pend_dec_nxt;
	logic [OAG_DW-1:0] step_in, step_out;

	oag_state_e state_r, state_nxt;
	logic valid_r, valid_nxt, dm_rd_r, dm_rd_nxt, noop_r, noop_nxt, rom_rd_r, rom_rd_nxt;
	logic [OAG_DW-1:0] op_r, op_nxt;
	logic [OAG_AW-1:0] dm_addr_r, dm_addr_nxt;
	logic [OAG_PCW-1:0] rom_addr_r, rom_addr_nxt;
	logic take;
	logic [OAG_AW-1:0] ea;

	// Register window stays visible whatever the bank, so pointers and stack are always reachable
	function automatic logic [OAG_AW-1:0] eff_addr(input logic [OAG_DW-1:0] a, input logic [OAG_DW-1:0] bank);
		if (a >= OAG_REG_WIN_LO)
			eff_addr = {1'b0, a};
		else
			eff_addr = {bank[0], a};
	endfunction : eff_addr

	function automatic logic [OAG_DW-1:0] rd_mem(input logic [OAG_AW-1:0] a);
		logic [OAG_AW-1:0] off;
		off = a - OAG_HIRAM_LO;
		if (a >= OAG_REGRAM_LO && a <= OAG_REGRAM_HI)
			rd_mem = regram[OAG_REGRAM_IW'(a - OAG_REGRAM_LO)];
		else if (a == OAG_PTR_TWO_ADDR)
			rd_mem = ptr_two_r;
		else if (a == OAG_STACK_ADDR)
			rd_mem = stack_r;
		else if (a == OAG_PTR_ONE_ADDR)
			rd_mem = ptr_one_r;
		else if (a == OAG_BANK_ADDR)
			rd_mem = bank_r;
		else if (a >= OAG_HIRAM_LO && a <= OAG_HIRAM_HI)
			rd_mem = hiram[off[OAG_HIRAM_IW-1:0]];
		else
			rd_mem = OAG_UNMAPPED_DATA;
	endfunction : rd_mem

	always_ff @(posedge i_core_clk)
	begin
		if (i_wr.en && i_wr.addr >= OAG_REGRAM_LO && i_wr.addr <= OAG_REGRAM_HI)
			regram[OAG_REGRAM_IW'(i_wr.addr - OAG_REGRAM_LO)] <= i_wr.data;
		if (i_wr.en && i_wr.addr >= OAG_HIRAM_LO && i_wr.addr <= OAG_HIRAM_HI)
			hiram[OAG_HIRAM_IW'(i_wr.addr - OAG_HIRAM_LO)] <= i_wr.data;
	end

	////////////////////////////////////////////////////////////////////////
	// Pointer registers and deferred adjustment
	assign step_in = pend_two_r ? ptr_two_r : ptr_one_r;

	oag_ptr_step #(.W(OAG_DW)) u_step (
		.i_value(step_in),
		.i_dec(pend_dec_r),
		.o_value(step_out)
	);

	always_comb
	begin
		ptr_one_nxt = ptr_one_r;
		ptr_two_nxt = ptr_two_r;
		stack_nxt = stack_r;
		bank_nxt = bank_r;
		pend_nxt = pend_r;
		pend_two_nxt = pend_two_r;
		pend_dec_nxt = pend_dec_r;
		// Adjust lands when the instruction is done, never at operand fetch
		if (pend_r && i_exec_done)
		begin
			pend_nxt = 1'b0;
			if (pend_two_r)
				ptr_two_nxt = step_out;
			else
				ptr_one_nxt = step_out;
		end
		if (take && i_req.mode == OAG_M_INDIRECT_ADJ)
		begin
			pend_nxt = 1'b1;
			pend_two_nxt = i_req.ptr_two;
			pend_dec_nxt = i_req.adj_dec;
		end
		// A direct store to a pointer overrides a concurrent adjustment
		if (i_wr.en)
		begin
			case (i_wr.addr)
				OAG_PTR_TWO_ADDR: ptr_two_nxt = i_wr.data;
				OAG_STACK_ADDR: stack_nxt = i_wr.data;
				OAG_PTR_ONE_ADDR: ptr_one_nxt = i_wr.data;
				OAG_BANK_ADDR: bank_nxt = i_wr.data;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			ptr_one_r <= OAG_REG_RESET;
			ptr_two_r <= OAG_REG_RESET;
			stack_r <= OAG_REG_RESET;
			bank_r <= OAG_REG_RESET;
			pend_r <= 1'b0;
			pend_two_r <= 1'b0;
			pend_dec_r <= 1'b0;
		end
		else
		begin
			ptr_one_r <= ptr_one_nxt;
			ptr_two_r <= ptr_two_nxt;
			stack_r <= stack_nxt;
			bank_r <= bank_nxt;
			pend_r <= pend_nxt;
			pend_two_r <= pend_two_nxt;
			pend_dec_r <= pend_dec_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Operand resolution
	assign take = i_req_valid && state_r == OAG_S_IDLE;
	assign ea = eff_addr(i_req.ptr_two ? ptr_two_r : ptr_one_r, bank_r);

	always_comb
	begin
		state_nxt = state_r;
		valid_nxt = 1'b0;
		dm_rd_nxt = 1'b0;
		noop_nxt = 1'b0;
		rom_rd_nxt = 1'b0;
		op_nxt = op_r;
		dm_addr_nxt = dm_addr_r;
		rom_addr_nxt = rom_addr_r;
		case (state_r)
			OAG_S_IDLE:
			begin
				if (take)
				begin
					case (i_req.mode)
						OAG_M_INDIRECT, OAG_M_INDIRECT_ADJ:
						begin
							dm_addr_nxt = ea;
							op_nxt = rd_mem(ea);
							dm_rd_nxt = 1'b1;
							valid_nxt = 1'b1;
						end
						OAG_M_DIRECT:
						begin
							dm_addr_nxt = eff_addr(i_req.field, bank_r);
							op_nxt = rd_mem(eff_addr(i_req.field, bank_r));
							dm_rd_nxt = 1'b1;
							valid_nxt = 1'b1;
						end
						OAG_M_IMMEDIATE:
						begin
							op_nxt = i_req.field;
							valid_nxt = 1'b1;
						end
						OAG_M_SHORT_IMM:
						begin
							op_nxt = {OAG_SI_PAD, i_req.field[OAG_SIW-1:0]};
							valid_nxt = 1'b1;
						end
						OAG_M_ROM_TABLE:
						begin
							rom_addr_nxt = {i_pc_upper, i_acc};
							rom_rd_nxt = 1'b1;
							state_nxt = OAG_S_ROM;
						end
						default: noop_nxt = 1'b1;
					endcase
				end
			end
			OAG_S_ROM:
			begin
				op_nxt = i_rom_data;
				valid_nxt = 1'b1;
				state_nxt = OAG_S_IDLE;
			end
			default: state_nxt = OAG_S_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			state_r <= OAG_S_IDLE;
			valid_r <= 1'b0;
			dm_rd_r <= 1'b0;
			noop_r <= 1'b0;
			rom_rd_r <= 1'b0;
			op_r <= OAG_REG_RESET;
			dm_addr_r <= '0;
			rom_addr_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			valid_r <= valid_nxt;
			dm_rd_r <= dm_rd_nxt;
			noop_r <= noop_nxt;
			rom_rd_r <= rom_rd_nxt;
			op_r <= op_nxt;
			dm_addr_r <= dm_addr_nxt;
			rom_addr_r <= rom_addr_nxt;
		end
	end

	assign o_busy = state_r != OAG_S_IDLE;
	assign o_operand_valid = valid_r;
	assign o_operand = op_r;
	assign o_dm_rd = dm_rd_r;
	assign o_dm_addr = dm_addr_r;
	assign o_no_operand = noop_r;
	assign o_rom_rd = rom_rd_r;
	assign o_rom_addr = rom_addr_r;
	assign o_ptr_one = ptr_one_r;
	assign o_ptr_two = ptr_two_r;
	assign o_stack_ptr = stack_r;
	assign o_upper_bank = bank_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	chk_ctl_modes: assert property (take && i_req.mode >= OAG_M_CTL_RELATIVE |=> o_no_operand && !o_operand_valid)
		else $error("control mode produced an operand");
	chk_indirect_addr: assert property (take && i_req.mode == OAG_M_INDIRECT && !i_req.ptr_two
		|=> o_dm_rd && o_dm_addr[OAG_DW-1:0] == $past(ptr_one_r))
		else $error("indirect address not taken from pointer one");
	chk_adjust_late: assert property (take && i_req.mode == OAG_M_INDIRECT_ADJ && i_req.ptr_two && !pend_r && !i_wr.en
		|=> ptr_two_r == $past(ptr_two_r) && pend_r)
		else $error("pointer moved before instruction end");
	chk_adjust_step: assert property (pend_r && i_exec_done && !pend_two_r && !pend_dec_r && !i_wr.en
		|=> ptr_one_r == OAG_DW'($past(ptr_one_r) + 8'h01))
		else $error("post increment wrong");
	chk_direct_addr: assert property (take && i_req.mode == OAG_M_DIRECT && i_req.field >= OAG_REG_WIN_LO
		|=> o_operand_valid && o_dm_addr == {1'b0, $past(i_req.field)})
		else $error("direct address wrong");
	chk_imm_value: assert property (take && i_req.mode == OAG_M_IMMEDIATE
		|=> o_operand_valid && !o_dm_rd && o_operand == $past(i_req.field))
		else $error("immediate operand wrong");
	chk_short_imm: assert property (take && i_req.mode == OAG_M_SHORT_IMM
		|=> o_operand == {OAG_SI_PAD, $past(i_req.field[OAG_SIW-1:0])})
		else $error("short immediate wrong");
	chk_rom_fetch: assert property (take && i_req.mode == OAG_M_ROM_TABLE
		|=> o_rom_rd && o_rom_addr == {$past(i_pc_upper), $past(i_acc)} && !o_operand_valid
		##1 o_operand_valid && o_operand == $past(i_rom_data))
		else $error("table load sequence wrong");
	chk_reg_stack: assert property (take && i_req.mode == OAG_M_DIRECT && i_req.field == OAG_STACK_ADDR[OAG_DW-1:0]
		|=> o_operand == $past(stack_r))
		else $error("stack pointer not visible in register window");

	cov_rom: cover property (take && i_req.mode == OAG_M_ROM_TABLE ##2 o_operand_valid);
	cov_adj: cover property (take && i_req.mode == OAG_M_INDIRECT_ADJ ##[1:8] pend_r && i_exec_done);
	cov_hiram: cover property (o_operand_valid && o_dm_addr >= OAG_HIRAM_LO);
endmodule : oag_core

/* File: hw/oag_pkg.sv */
package oag_pkg;

	// Widths
	localparam int OAG_DW = 8;
	localparam int OAG_AW = 9;
	localparam int OAG_PCW = 15;
	localparam int OAG_PUW = 7;
	localparam int OAG_SIW = 4;

	// Data memory map
	localparam logic [OAG_AW-1:0] OAG_REGRAM_LO = 9'h0F0;
	localparam logic [OAG_AW-1:0] OAG_REGRAM_HI = 9'h0FB;
	localparam logic [OAG_AW-1:0] OAG_PTR_TWO_ADDR = 9'h0FC;
	localparam logic [OAG_AW-1:0] OAG_STACK_ADDR = 9'h0FD;
	localparam logic [OAG_AW-1:0] OAG_PTR_ONE_ADDR = 9'h0FE;
	localparam logic [OAG_AW-1:0] OAG_BANK_ADDR = 9'h0FF;
	localparam logic [OAG_AW-1:0] OAG_HIRAM_LO = 9'h100;
	localparam logic [OAG_AW-1:0] OAG_HIRAM_HI = 9'h13F;
	localparam logic [OAG_DW-1:0] OAG_REG_WIN_LO = 8'hF0;
	localparam int OAG_REGRAM_DEPTH = 12;
	localparam int OAG_HIRAM_DEPTH = 64;
	localparam int OAG_REGRAM_IW = 4;
	localparam int OAG_HIRAM_IW = 6;

	// Reset and fill values
	localparam logic [OAG_DW-1:0] OAG_REG_RESET = 8'h00;
	localparam logic [OAG_DW-1:0] OAG_UNMAPPED_DATA = 8'h00;
	localparam logic [OAG_SIW-1:0] OAG_SI_PAD = 4'h0;

	// Ten addressing modes: six operand, four transfer of control
	typedef enum logic [3:0] {
		OAG_M_INDIRECT,
		OAG_M_INDIRECT_ADJ,
		OAG_M_DIRECT,
		OAG_M_IMMEDIATE,
		OAG_M_SHORT_IMM,
		OAG_M_ROM_TABLE,
		OAG_M_CTL_RELATIVE,
		OAG_M_CTL_ABSOLUTE,
		OAG_M_CTL_ABS_LONG,
		OAG_M_CTL_INDIRECT
	} oag_mode_e;

	typedef struct packed {
		oag_mode_e mode;
		logic ptr_two;
		logic adj_dec;
		logic [OAG_DW-1:0] field;
	} oag_req_s;

	typedef struct packed {
		logic en;
		logic [OAG_AW-1:0] addr;
		logic [OAG_DW-1:0] data;
	} oag_wr_s;

endpackage : oag_pkg

/* File: hw/oag_ptr_step.sv */
`timescale 1ns/1ps
module oag_ptr_step #(
	parameter int W = 8
) (
	input wire logic [W-1:0] i_value,
	input wire logic i_dec,
	output logic [W-1:0] o_value
);
	// Natural wrap of a W-bit sum gives modulo 2**W stepping
	always_comb
	begin
		if (i_dec)
			o_value = i_value - W'(1);
		else
			o_value = i_value + W'(1);
	end
endmodule : oag_ptr_step
